// ==== hw/amitp_pkg.sv ====
/*
  Shared constants and carrier types of the converter control block:
  register indices, field positions, reset values, pattern modes and
  timing counts. Assumes a 20 MHz register clock.
*/
package amitp_pkg;

  // Register clock
  localparam int unsigned CLK_PERIOD_NS = 50;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_RESET_CTRL = 8'h00;
  localparam logic [7:0] IDX_BANK_SEL   = 8'h03;
  localparam logic [7:0] IDX_TRIM_A     = 8'h04;
  localparam logic [7:0] IDX_STATUS     = 8'h07;
  localparam logic [7:0] IDX_PAGED_BASE = 8'h08;
  localparam logic [7:0] IDX_TRIM_E     = 8'h0a;
  localparam logic [7:0] IDX_FMT_GAIN   = 8'h0d;
  localparam logic [7:0] IDX_TRIM_C     = 8'h12;
  localparam logic [7:0] IDX_PAT_CTRL_A = 8'h13;
  localparam logic [7:0] IDX_TRIM_D     = 8'h13;
  localparam logic [7:0] IDX_PAT_W0_A   = 8'h14;
  localparam logic [7:0] IDX_PAT_W1_A   = 8'h15;
  localparam logic [7:0] IDX_PAT_CTRL_B = 8'h18;
  localparam logic [7:0] IDX_PAT_W0_B   = 8'h19;
  localparam logic [7:0] IDX_PAT_W1_B   = 8'h1a;
  localparam logic [7:0] IDX_UNLOCK     = 8'h33;
  localparam logic [7:0] IDX_CHAN_PD    = 8'hc0;
  localparam logic [7:0] IDX_CAL_TRIG   = 8'hf4;
  localparam logic [7:0] IDX_TRIM_B     = 8'hf6;

  // Field positions
  localparam int unsigned RESET_BIT     = 0;
  localparam int unsigned BANK1_BIT     = 1;
  localparam int unsigned BANK2_BIT     = 4;
  localparam int unsigned PAT_EN_BIT    = 0;
  localparam int unsigned PAT_MODE_LSB  = 1;
  localparam int unsigned RAMP_INC_LSB  = 4;
  localparam int unsigned PD_LSB        = 0;
  localparam logic [1:0]  PD_ALL        = 2'h3;
  localparam int unsigned ST_VALID_BIT  = 0;
  localparam int unsigned ST_PD_BIT     = 1;
  localparam int unsigned ST_CLEAR_BIT  = 2;

  // Values after reset
  localparam logic [15:0] REG_RESET_VAL = 16'h0000;

  // Timing: sampling clock counted as stopped after this long
  localparam int unsigned STOP_TIME_NS  = 1000;
  localparam logic [7:0]  STOP_CYCLES   =
    8'(STOP_TIME_NS / CLK_PERIOD_NS);
  // Sampling edges before outputs become valid
  localparam logic [7:0]  PU_EDGES      = 8'h10;

  // Widths
  localparam int unsigned SAMPLE_W      = 18;
  localparam int unsigned MEM_AW        = 9;

  // Test pattern selections
  typedef enum logic [1:0] {
    PAT_FIXED     = 2'h0,
    PAT_FIXED_ALT = 2'h1,
    PAT_RAMP      = 2'h2,
    PAT_ALTERNATE = 2'h3
  } amitp_mode_t;

  // Both channels of one sample
  typedef struct packed {
    logic [1:0][SAMPLE_W-1:0] chan;
  } amitp_sample_t;

endpackage

// ==== hw/amitp_regmem.sv ====
/*
  Paged register storage: two banks of 256 words, one write port,
  one read port with registered read data. Assumes one clock.
*/
`timescale 1ns/1ns
`default_nettype none
module amitp_regmem
  import amitp_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              we,
  input  wire logic [MEM_AW-1:0] waddr,
  input  wire logic [15:0]       wdata,
  input  wire logic [MEM_AW-1:0] raddr,
  output logic      [15:0]       rdata_r
);

  logic [15:0] mem [2**MEM_AW];

  // Write port and registered read
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_r <= mem[raddr];
  end

endmodule
`default_nettype wire

// ==== hw/amitp_ctrl.sv ====
/*
  Converter control block: APB register slave with bank paging, test
  pattern substitution (fixed, alternating, ramp), reset and power-down
  handling, sampling-clock presence tracking and sample output.
  Assumes conversion data, reset and power-down pins and the sampling
  clock arrive synchronous to pclk.
*/
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Enable 1, mode 3: output the two pattern words alternately.
// - Enable 1, mode 2: output a digital ramp instead of data.
// - Ramp step equals increment field plus one.
// - Outputs are invalid while sampling clock stopped, valid after warm-up.
// - Reset pin low or reset field write restores register defaults.
// - Power-down pin low or channel field 11b powers down.
// - Registers hold defaults after power-up; host then runs init sequence.
// - Both inputs sampled on each falling sampling clock edge.
// - Outputs bit clock, frame clock and 18-bit MSB-aligned results.
// - After the sequence registers hold defaults except the final writes.
// - Enable 0 passes real conversion data; enable 1 substitutes pattern.
// - Enable 1, mode 0: output first pattern word as constant.
// - Bank select picks bank one or two; bank zero always reachable.
module amitp_ctrl
  import amitp_pkg::*;
(
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     device_reset_n,
  input  wire logic                     power_down_pin_n,
  input  wire logic                     sampling_clock,
  input  wire amitp_pkg::amitp_sample_t conv_data,
  output amitp_pkg::amitp_sample_t      sample_out,
  output logic                          sample_valid,
  output logic                          output_bit_clock,
  output logic                          frame_clock,
  output logic                          powered_down
);
  import amitp_pkg::*;

  typedef enum logic [1:0] {BUS_IDLE, BUS_READ, BUS_ACK} amitp_bus_t;

  // Software-visible registers held in flops
  typedef struct packed {
    logic [15:0]      ctrl0;
    logic [15:0]      bank_sel;
    logic [15:0]      trim_a;
    logic [1:0][15:0] pat_ctrl;
    logic [1:0][15:0] pat_w0;
    logic [1:0][15:0] pat_w1;
    logic [1:0]       chan_pd;
  } amitp_regs_t;

  typedef struct packed {
    amitp_bus_t               bus;
    logic [31:0]              prdata;
    logic                     pready;
    logic                     pslverr;
    amitp_regs_t              regs;
    logic                     clearing;
    logic [MEM_AW-1:0]        clear_cnt;
    logic                     pd;
    logic                     smp_prev;
    logic [7:0]               idle_cnt;
    logic [7:0]               pu_cnt;
    logic                     valid;
    logic [1:0][SAMPLE_W-1:0] ramp;
    logic [1:0]               alt_phase;
    amitp_sample_t            out;
    logic                     bit_clk;
    logic                     frame_clk;
  } amitp_state_t;

  amitp_state_t      s_r;
  amitp_state_t      s_nxt;
  logic [7:0]        idx;
  logic              paged;
  logic              bank1;
  logic              bank2;
  logic              b0_hit;
  logic              mapped;
  logic              commit;
  logic              commit_paged;
  logic              mem_we;
  logic [MEM_AW-1:0] mem_addr;
  logic [MEM_AW-1:0] mem_waddr;
  logic [15:0]       mem_wdata;
  logic [15:0]       mem_rdata;
  logic [15:0]       b0_rdata;
  logic              pd_now;
  logic              fall;

  // Address decode; paged addresses follow the bank select
  assign idx    = paddr[9:2];
  assign paged  = (idx >= IDX_PAGED_BASE);
  assign bank1  = s_r.regs.bank_sel[BANK1_BIT];
  assign bank2  = s_r.regs.bank_sel[BANK2_BIT] & ~bank1;
  assign b0_hit = (idx == IDX_RESET_CTRL) || (idx == IDX_BANK_SEL) ||
                  (idx == IDX_TRIM_A) || (idx == IDX_STATUS);
  assign mapped = (paddr[11:10] == 2'h0) &&
                  (paged ? (bank1 | bank2) : b0_hit);
  assign mem_addr = {bank2, idx};

  // A write lands at the edge where pready is seen high
  assign commit       = psel & penable & pwrite & s_r.pready & mapped;
  assign commit_paged = commit & paged;
  assign mem_we       = s_r.clearing | commit_paged;
  assign mem_waddr    = s_r.clearing ? s_r.clear_cnt : mem_addr;
  assign mem_wdata    = s_r.clearing ? REG_RESET_VAL : pwdata[15:0];

  // Power down from pin or register field
  assign pd_now = ~power_down_pin_n |
                  (s_r.regs.chan_pd == PD_ALL);
  assign fall   = s_r.smp_prev & ~sampling_clock;

  // Bank zero read data
  always_comb begin
    b0_rdata = REG_RESET_VAL;
    case (idx)
      IDX_RESET_CTRL: b0_rdata = s_r.regs.ctrl0;
      IDX_BANK_SEL:   b0_rdata = s_r.regs.bank_sel;
      IDX_TRIM_A:     b0_rdata = s_r.regs.trim_a;
      IDX_STATUS: begin
        b0_rdata[ST_VALID_BIT] = s_r.valid;
        b0_rdata[ST_PD_BIT]    = s_r.pd;
        b0_rdata[ST_CLEAR_BIT] = s_r.clearing;
      end
      default:        b0_rdata = REG_RESET_VAL;
    endcase
  end

  amitp_regmem u_regmem (
    .pclk    (pclk),
    .we      (mem_we),
    .waddr   (mem_waddr),
    .wdata   (mem_wdata),
    .raddr   (mem_addr),
    .rdata_r (mem_rdata)
  );

  // Next-state logic
  always_comb begin
    s_nxt         = s_r;
    s_nxt.pready  = 1'b0;
    s_nxt.pslverr = 1'b0;

    // Bus handshake; stalls while the paged banks are being cleared
    case (s_r.bus)
      BUS_IDLE: begin
        if (psel && penable && !s_r.clearing) begin
          if (pwrite || !mapped || !paged) begin
            s_nxt.prdata  = (pwrite || !mapped) ? 32'h0 : {16'h0, b0_rdata};
            s_nxt.pready  = 1'b1;
            s_nxt.pslverr = ~mapped;
            s_nxt.bus     = BUS_ACK;
          end else begin
            s_nxt.bus = BUS_READ;
          end
        end
      end
      BUS_READ: begin
        s_nxt.prdata = {16'h0, mem_rdata};
        s_nxt.pready = 1'b1;
        s_nxt.bus    = BUS_ACK;
      end
      BUS_ACK: s_nxt.bus = BUS_IDLE;
      default: s_nxt.bus = BUS_IDLE;
    endcase

    // Bank zero writes
    if (commit && !paged) begin
      case (idx)
        IDX_RESET_CTRL: begin
          s_nxt.regs.ctrl0 = pwdata[15:0];
          s_nxt.regs.ctrl0[RESET_BIT] = 1'b0;
        end
        IDX_BANK_SEL:   s_nxt.regs.bank_sel = pwdata[15:0];
        IDX_TRIM_A:     s_nxt.regs.trim_a = pwdata[15:0];
        default:        s_nxt.regs.trim_a = s_r.regs.trim_a;
      endcase
    end

    // Shadows of bank one registers that steer the pattern and power-down logic
    if (commit_paged && bank1) begin
      case (idx)
        IDX_PAT_CTRL_A: s_nxt.regs.pat_ctrl[0] = pwdata[15:0];
        IDX_PAT_CTRL_B: s_nxt.regs.pat_ctrl[1] = pwdata[15:0];
        IDX_PAT_W0_A:   s_nxt.regs.pat_w0[0] = pwdata[15:0];
        IDX_PAT_W0_B:   s_nxt.regs.pat_w0[1] = pwdata[15:0];
        IDX_PAT_W1_A:   s_nxt.regs.pat_w1[0] = pwdata[15:0];
        IDX_PAT_W1_B:   s_nxt.regs.pat_w1[1] = pwdata[15:0];
        IDX_CHAN_PD:    s_nxt.regs.chan_pd = pwdata[PD_LSB +: 2];
        default:        s_nxt.regs.chan_pd = s_r.regs.chan_pd;
      endcase
    end

    // Walk the paged banks back to their defaults
    if (s_r.clearing) begin
      s_nxt.clear_cnt = s_r.clear_cnt + 1'b1;
      if (&s_r.clear_cnt) begin
        s_nxt.clearing = 1'b0;
      end
    end

    // Sampling clock presence; stopped clock drops validity
    s_nxt.smp_prev  = sampling_clock;
    s_nxt.pd        = pd_now;
    s_nxt.frame_clk = 1'b0;
    if (fall) begin
      s_nxt.idle_cnt = 8'h0;
    end else if (s_r.idle_cnt != STOP_CYCLES) begin
      s_nxt.idle_cnt = s_r.idle_cnt + 8'h1;
    end
    if (s_r.idle_cnt == STOP_CYCLES || pd_now) begin
      s_nxt.pu_cnt = 8'h0;
      s_nxt.valid  = 1'b0;
    end else if (fall) begin
      if (s_r.pu_cnt != PU_EDGES) begin
        s_nxt.pu_cnt = s_r.pu_cnt + 8'h1;
      end
      s_nxt.valid = (s_r.pu_cnt == PU_EDGES);
    end

    // Per-channel sample capture and pattern substitution
    if (fall && !pd_now) begin
      for (int c = 0; c < 2; c++) begin
        s_nxt.out.chan[c] = conv_data.chan[c];
        if (s_r.regs.pat_ctrl[c][PAT_EN_BIT]) begin
          case (amitp_mode_t'(s_r.regs.pat_ctrl[c][PAT_MODE_LSB +: 2]))
            PAT_RAMP: begin
              s_nxt.out.chan[c] = s_r.ramp[c];
              s_nxt.ramp[c] = s_r.ramp[c] + SAMPLE_W'(
                {1'b0, s_r.regs.pat_ctrl[c][RAMP_INC_LSB +: 8]}
                + 9'h1);
            end
            PAT_ALTERNATE: begin
              s_nxt.out.chan[c] = s_r.alt_phase[c] ?
                {s_r.regs.pat_w1[c], 2'h0} :
                {s_r.regs.pat_w0[c], 2'h0};
              s_nxt.alt_phase[c] = ~s_r.alt_phase[c];
            end
            default: begin
              s_nxt.out.chan[c] = {s_r.regs.pat_w0[c], 2'h0};
            end
          endcase
        end
      end
      s_nxt.frame_clk = s_nxt.valid;
    end

    // Bit clock runs only while outputs are valid
    s_nxt.bit_clk = s_r.valid & ~s_r.bit_clk;
    if (!s_nxt.valid) begin
      s_nxt.out = '0;
    end

    // Reset from pin, reset field or leaving power down
    if (!device_reset_n || (commit && !paged && idx == IDX_RESET_CTRL &&
        pwdata[RESET_BIT]) || (s_r.pd && !pd_now)) begin
      s_nxt.regs      = '0;
      s_nxt.clearing  = 1'b1;
      s_nxt.clear_cnt = '0;
      s_nxt.ramp      = '0;
      s_nxt.alt_phase = '0;
      s_nxt.pu_cnt    = 8'h0;
      s_nxt.valid     = 1'b0;
      s_nxt.out       = '0;
      s_nxt.frame_clk = 1'b0;
    end
  end

  // State register; after reset the paged banks are cleared first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r          <= '0;
      s_r.clearing <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign prdata           = s_r.prdata;
  assign pready           = s_r.pready;
  assign pslverr          = s_r.pslverr;
  assign sample_out       = s_r.out;
  assign sample_valid     = s_r.valid;
  assign output_bit_clock = s_r.bit_clk;
  assign frame_clock      = s_r.frame_clk;
  assign powered_down     = s_r.pd;

endmodule
`default_nettype wire

// ==== tb/amitp_checker.sv ====
/*
  Port checker of the converter control block: bus answers, power-down,
  sample framing. Bound to the top module; sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module amitp_checker
  import amitp_pkg::*;
(
  input wire logic                     pclk,
  input wire logic                     presetn,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic [31:0]              prdata,
  input wire logic                     pready,
  input wire logic                     pslverr,
  input wire logic                     device_reset_n,
  input wire logic                     power_down_pin_n,
  input wire logic                     sampling_clock,
  input wire amitp_pkg::amitp_sample_t sample_out,
  input wire logic                     sample_valid,
  input wire logic                     output_bit_clock,
  input wire logic                     frame_clock,
  input wire logic                     powered_down
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Bus answers stay within one access cycle
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_upper: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  // Power-down and reset
  a_pin_powers_down: assert property (
    !power_down_pin_n |-> ##[1:2] powered_down)
    else $error("power-down pin ignored");
  a_down_no_data: assert property (
    powered_down |-> ##[0:2] !sample_valid)
    else $error("valid samples while powered down");
  a_reset_pin: assert property (
    !device_reset_n |-> ##[1:2] !sample_valid)
    else $error("reset pin left outputs valid");
  // Sample framing
  a_idle_out_zero: assert property (
    !sample_valid |-> sample_out == '0)
    else $error("sample data while invalid");
  a_idle_no_clocks: assert property (
    !sample_valid && !$past(sample_valid)
      |-> !output_bit_clock && !frame_clock)
    else $error("clocks running while invalid");
  a_fall_frames: assert property (
    sample_valid && $fell(sampling_clock) && !powered_down
      && power_down_pin_n && device_reset_n
      |=> frame_clock == sample_valid)
    else $error("falling sampling edge without frame");
  a_frame_single: assert property (frame_clock |=> !frame_clock)
    else $error("frame pulse longer than one cycle");
  a_bitclk_toggle: assert property (
    sample_valid && $past(sample_valid)
      |-> output_bit_clock != $past(output_bit_clock))
    else $error("bit clock not toggling while valid");
endmodule
`default_nettype wire

// ==== tb/amitp_sampler_model.sv ====
/*
  Far-side model: sampling clock at pclk/8 and conversion data.
  Stands still at its level while run is low.
*/
`timescale 1ns/1ns
`default_nettype none
module amitp_sampler_model
  import amitp_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                run,
  output logic                     sampling_clock,
  output amitp_pkg::amitp_sample_t conv_data
);
  logic [1:0]  div_r;
  logic [17:0] cnt_r;

  initial begin
    sampling_clock = 1'b1;
    div_r = 2'h0;
    cnt_r = 18'h00000;
    conv_data = '0;
  end

  // Clock runs while run is high; new data on each rising edge
  always @(posedge pclk) begin
    if (run) begin
      div_r <= div_r + 2'h1;
      if (div_r == 2'h3) begin
        sampling_clock <= !sampling_clock;
        if (!sampling_clock) begin
          cnt_r <= cnt_r + 18'h00001;
          conv_data.chan[0] <= cnt_r + 18'h00111;
          conv_data.chan[1] <= ~cnt_r;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/tb_amitp_ctrl.sv ====
/*
  Testbench of the converter control block: APB register tasks,
  pattern modes, clock stop, power-down and reset. Uses the model.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  error_cnt++; $display("Error t=%0t got %h exp %h", $time, (a), (b)); \
  end end
module tb_amitp_ctrl;
  import amitp_pkg::*;
  localparam logic [17:0] W0A = {16'h1234, 2'b00};
  localparam logic [17:0] W1A = {16'habcd, 2'b00};
  // Minimum host waits, rounded up to whole cycles
  localparam int WAIT_10US =
    (10000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAIT_1MS  =
    (1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] USER_FMT = 16'h0005; // Arbitrary format choice
  logic          pclk, presetn, psel, penable, pwrite, err, run;
  logic          dev_rst_n, pd_n, pready, pslverr, smp_clk, valid;
  logic          bit_clk, frame_clock, powered_down, bclk_prev;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata;
  logic [15:0]   rd;
  amitp_sample_t conv, sample_out, s1, s2;
  int            error_cnt, check_count;

  always #25 pclk = ~pclk;

  amitp_ctrl u_amitp_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .device_reset_n(dev_rst_n), .power_down_pin_n(pd_n),
    .sampling_clock(smp_clk), .conv_data(conv), .sample_out(sample_out),
    .sample_valid(valid), .output_bit_clock(bit_clk),
    .frame_clock(frame_clock), .powered_down(powered_down));
  amitp_sampler_model u_amitp_sampler_model (.pclk(pclk), .run(run),
    .sampling_clock(smp_clk), .conv_data(conv));

  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // One APB transfer; waits for pready
  task automatic apb(input logic w, input logic [7:0] i,
                     input logic [15:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 3000);
    rd = prdata[15:0];
    err = pslverr;
    if (pready !== 1'b1) error_cnt++; // Wait limit ran out
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk); // Idle edge keeps requests apart
  endtask

  task automatic wr(input logic [7:0] i, input logic [15:0] d);
    apb(1'b1, i, d);
    `CHK(err, 1'b0)
  endtask

  // Next sample at its frame pulse
  task automatic get(output amitp_sample_t s);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (frame_clock !== 1'b1 && n < 200);
    s = sample_out;
    `CHK(frame_clock, 1'b1)
  endtask

  task automatic wait_valid;
    int n;
    n = 0;
    while (valid !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
  endtask

  // Host wait counted on its own clock
  task automatic pause(input int cycles);
    repeat (cycles) @(posedge pclk);
  endtask

  // Start-up write sequence with its minimum waits
  task automatic init_seq;
    wr(IDX_BANK_SEL, 16'h0002);
    wr(IDX_TRIM_B, 16'h0002);
    wr(IDX_TRIM_A, 16'h000b);
    wr(IDX_BANK_SEL, 16'h0010);
    wr(IDX_TRIM_C, 16'h0040);
    wr(IDX_TRIM_D, 16'h8000);
    wr(IDX_TRIM_E, 16'h4000);
    pause(WAIT_10US);
    wr(IDX_TRIM_E, 16'h0000);
    wr(IDX_BANK_SEL, 16'h0002);
    wr(IDX_TRIM_B, 16'h0000);
    wr(IDX_BANK_SEL, 16'h0010);
    wr(IDX_TRIM_D, 16'h0000);
    wr(IDX_TRIM_C, 16'h0000);
    wr(IDX_TRIM_A, 16'h0000);
    wr(IDX_BANK_SEL, 16'h0002);
    wr(IDX_UNLOCK, 16'h0030);
    wr(IDX_CAL_TRIG, 16'h0000);
    wr(IDX_CAL_TRIG, 16'h0002);
    pause(WAIT_1MS);
    wr(IDX_CAL_TRIG, 16'h0000);
    pause(WAIT_1MS);
    wr(IDX_UNLOCK, 16'h0000);
    wr(IDX_FMT_GAIN, USER_FMT);
    wr(IDX_UNLOCK, 16'h2040);
  endtask

  // Main sequence
  initial begin
    pclk        = 1'b0;
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = '0;
    pwdata      = '0;
    dev_rst_n   = 1'b1;
    pd_n        = 1'b1;
    run         = 1'b1;
    error_cnt   = 0;
    check_count = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, IDX_BANK_SEL, 16'h0); `CHK(rd, 16'h0000)
    apb(1'b0, 8'h01, 16'h0); `CHK(err, 1'b1)
    apb(1'b0, IDX_PAT_CTRL_A, 16'h0); `CHK(err, 1'b1)
    init_seq;
    apb(1'b0, IDX_TRIM_B, 16'h0); `CHK(rd, 16'h0000)
    apb(1'b0, IDX_CAL_TRIG, 16'h0); `CHK(rd, 16'h0000)
    apb(1'b0, IDX_FMT_GAIN, 16'h0); `CHK(rd, USER_FMT)
    apb(1'b0, IDX_UNLOCK, 16'h0); `CHK(rd, 16'h2040)
    apb(1'b0, IDX_TRIM_A, 16'h0); `CHK(rd, 16'h0000)
    wr(IDX_BANK_SEL, 16'h0010);
    apb(1'b0, IDX_TRIM_E, 16'h0); `CHK(rd, 16'h0000)
    apb(1'b0, IDX_TRIM_C, 16'h0); `CHK(rd, 16'h0000)
    wr(IDX_TRIM_D, 16'h8000);
    wr(IDX_BANK_SEL, 16'h0002);
    apb(1'b0, IDX_PAT_CTRL_A, 16'h0); `CHK(rd, 16'h0000)
    wr(IDX_PAT_W0_A, 16'h1234);
    wr(IDX_PAT_W1_A, 16'habcd);
    apb(1'b0, IDX_PAT_W0_A, 16'h0); `CHK(rd, 16'h1234)
    wait_valid; `CHK(valid, 1'b1)
    for (int m = 0; m < 4; m++) begin
      wr(IDX_PAT_CTRL_A, 16'h0051 | 16'(m << 1));
      get(s1); get(s1); get(s2);
      if (m == 2) `CHK(18'(s2.chan[0] - s1.chan[0]), 18'h00006)
      else if (m == 3) `CHK(s1.chan[0] ^ s2.chan[0], W0A ^ W1A)
      else `CHK(s2.chan[0], W0A)
      `CHK(s2.chan[1], conv.chan[1])
    end
    wr(IDX_PAT_CTRL_B, 16'h0005);
    get(s1); get(s1); get(s2);
    `CHK(18'(s2.chan[1] - s1.chan[1]), 18'h00001)
    run <= 1'b0;
    repeat (40) @(posedge pclk);
    `CHK(valid, 1'b0)
    run <= 1'b1;
    wait_valid; `CHK(valid, 1'b1)
    apb(1'b0, IDX_STATUS, 16'h0);
    `CHK(rd, 16'(1 << ST_VALID_BIT))
    bclk_prev = bit_clk;
    @(posedge pclk);
    `CHK(bit_clk, ~bclk_prev)
    wr(IDX_CHAN_PD, 16'h0003);
    repeat (3) @(posedge pclk);
    `CHK(powered_down, 1'b1)
    wr(IDX_CHAN_PD, 16'h0000);
    apb(1'b0, IDX_BANK_SEL, 16'h0); `CHK(rd, 16'h0000)
    pd_n <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK(powered_down, 1'b1)
    pd_n <= 1'b1;
    wr(IDX_BANK_SEL, 16'h0002);
    wr(IDX_RESET_CTRL, 16'h0001);
    apb(1'b0, IDX_BANK_SEL, 16'h0); `CHK(rd, 16'h0000)
    wr(IDX_BANK_SEL, 16'h0002);
    dev_rst_n <= 1'b0;
    repeat (2) @(posedge pclk);
    dev_rst_n <= 1'b1;
    apb(1'b0, IDX_BANK_SEL, 16'h0); `CHK(rd, 16'h0000)
    give_verdict;
  end

  // Watchdog against a hang, well past the expected run
  initial begin
    #3000000;
    error_cnt++;
    give_verdict;
  end
endmodule

bind amitp_ctrl amitp_checker u_amitp_checker (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .device_reset_n(device_reset_n),
  .power_down_pin_n(power_down_pin_n), .sampling_clock(sampling_clock),
  .sample_out(sample_out), .sample_valid(sample_valid),
  .output_bit_clock(output_bit_clock), .frame_clock(frame_clock),
  .powered_down(powered_down));
`default_nettype wire
